// ---- bench/dpsem_port_ctrl_properties.sv ----
`default_nettype none

module dpsem_port_ctrl_properties
  import dpsem_pkg::*;
#(
  parameter int IDX_W  = 3,
  parameter int DATA_W = 8
) (
  input wire logic              i_clk,            // Clock.
  input wire logic              i_reset,          // Reset.
  input wire logic              i_cmd_valid,      // Offer.
  input wire dpsem_cmd_t        i_cmd,            // Command.
  input wire logic              o_cmd_ready,      // Ready.
  input wire logic              o_done,           // Done.
  input wire logic              o_token_select_n, // Select.
  input wire logic              o_ram_select_n,   // Memory enable.
  input wire logic              o_oe_n,           // Enable.
  input wire logic              o_rw_n,           // Direction.
  input wire logic [IDX_W-1:0]  o_token_index,    // Index.
  input wire logic [DATA_W-1:0] o_data_out,       // Data.
  input wire logic              o_data_oe         // Drive.
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking dpsem_cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // A command counts only on an edge where both sides agree.
  logic taken;
  assign taken = i_cmd_valid && o_cmd_ready;

  AST_RAM_OFF: assert property (o_ram_select_n)
    else $error("memory enable went low");
  AST_WR_STROBE: assert property ($fell(o_token_select_n) && !o_rw_n |->
    (!o_token_select_n && !o_rw_n && o_data_oe)[*3] ##1 (o_token_select_n && o_rw_n && o_data_oe))
    else $error("write strobe shape wrong");
  AST_RD_STROBE: assert property ($fell(o_token_select_n) && o_rw_n |->
    (!o_token_select_n && !o_oe_n && !o_data_oe)[*3] ##1 (o_token_select_n && o_oe_n))
    else $error("read strobe shape wrong");
  AST_REPLICATE: assert property (o_data_oe |-> o_data_out == {DATA_W{o_data_out[0]}})
    else $error("write value not on all bits");
  AST_NO_FIGHT: assert property (!o_oe_n |-> !o_data_oe && o_rw_n)
    else $error("pins driven during read");
  AST_INDEX_HOLD: assert property (!o_token_select_n |-> $stable(o_token_index))
    else $error("index moved in access");
  AST_INIT_FIRST: assert property ($fell(i_reset) |->
    ##[1:8] ($fell(o_token_select_n) && !o_rw_n && o_data_out[0] && o_token_index == 0))
    else $error("start-up write missing");
  AST_ACQ_ZERO: assert property (taken && i_cmd == DPSEM_CMD_ACQUIRE |->
    ##[1:6] ($fell(o_token_select_n) && !o_rw_n && !o_data_out[0]))
    else $error("acquire did not write zero");
  AST_REL_ONE: assert property (taken && i_cmd == DPSEM_CMD_RELEASE |->
    ##[1:6] ($fell(o_token_select_n) && !o_rw_n && o_data_out[0]))
    else $error("release did not write one");
  AST_DONE_PULSE: assert property (o_done |=> !o_done && o_cmd_ready)
    else $error("done pulse wrong");

  // The three command kinds are each seen at least once.
  cover property (taken && i_cmd == DPSEM_CMD_ACQUIRE);
  cover property (taken && i_cmd == DPSEM_CMD_RELEASE);
  cover property (taken && i_cmd == DPSEM_CMD_INIT);
endmodule : dpsem_port_ctrl_properties

bind dpsem_port_ctrl dpsem_port_ctrl_properties #(.IDX_W(IDX_W), .DATA_W(DATA_W))
  dpsem_port_ctrl_properties_inst (.i_clk(i_clk), .i_reset(i_reset),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
  .o_token_select_n(o_token_select_n), .o_ram_select_n(o_ram_select_n), .o_oe_n(o_oe_n),
  .o_rw_n(o_rw_n), .o_token_index(o_token_index), .o_data_out(o_data_out),
  .o_data_oe(o_data_oe));

`default_nettype wire

// ---- bench/dpsem_port_ctrl_tb_top.sv ----
`default_nettype none

module dpsem_port_ctrl_tb_top
  import dpsem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, reset, valid, wof, ready, done, granted, sel_n, ram_n, oe_n, rw_n, doe;
  logic mdrv, r_wr, r_bit;
  dpsem_cmd_t cmd;
  logic [2:0] idx, tidx, r_idx, k;
  logic [7:0] held, din, dout, mdata, lf, rf, reql, exp_held;
  int cyc = 0, fails = 0, checks = 0, seed, i, c, base;

  // An idle wire shows a pattern that changes every cycle.
  assign din = mdrv ? mdata : (doe ? dout : (cyc[7:0] ^ 8'h5A));

  dpsem_port_ctrl #(.RETRY_MAX(2)) dpsem_port_ctrl_inst (.i_clk(clk), .i_reset(reset),
    .i_cmd_valid(valid), .i_cmd(cmd), .i_cmd_index(idx), .i_wait_on_fail(wof),
    .o_cmd_ready(ready), .o_done(done), .o_granted(granted), .o_held(held),
    .o_token_select_n(sel_n), .o_ram_select_n(ram_n), .o_oe_n(oe_n), .o_rw_n(rw_n),
    .o_token_index(tidx), .i_data_in(din), .o_data_out(dout), .o_data_oe(doe));
  dpsem_token_model dpsem_token_model_inst (.i_clk(clk), .i_sel_n(sel_n), .i_oe_n(oe_n),
    .i_rw_n(rw_n), .i_idx(tidx), .i_bus(din), .i_r_wr(r_wr), .i_r_bit(r_bit),
    .i_r_idx(r_idx), .o_data(mdata), .o_drive(mdrv), .o_l_flags(lf), .o_r_flags(rf),
    .o_req_l(reql));

  // The clock runs at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [7:0] upd(input logic [7:0] m, input logic [2:0] n, input logic v);
    upd = m;
    upd[n] = v;
  endfunction : upd

  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : cmp1

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp8

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic wait_done;
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    #1;
  endtask : wait_done

  // The right port writes its flag directly, one edge wide.
  task automatic rwrite(input logic b, input logic [2:0] n);
    @(posedge clk);
    r_wr <= 1'b1;
    r_bit <= b;
    r_idx <= n;
    @(posedge clk);
    r_wr <= 1'b0;
    #1;
  endtask : rwrite

  task automatic run(input dpsem_cmd_t cc, input logic [2:0] n, input logic w);
    @(posedge clk);
    valid <= 1'b1;
    cmd <= cc;
    idx <= n;
    wof <= w;
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
    wait_done();
  endtask : run

  task automatic acq(input logic [2:0] n, input logic w, input logic e);
    run(DPSEM_CMD_ACQUIRE, n, w);
    exp_held = upd(exp_held, n, e);
    cmp1("granted", e, granted);
    cmp8("held", exp_held, held);
  endtask : acq

  task automatic rel(input logic [2:0] n);
    run(DPSEM_CMD_RELEASE, n, 1'b0);
    exp_held = upd(exp_held, n, 1'b0);
    cmp1("granted", 1'b0, granted);
    cmp8("held", exp_held, held);
  endtask : rel

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    seed = 36773;
    {reset, r_bit} = 2'b11;
    {valid, wof, r_wr} = 3'b000;
    {idx, r_idx, exp_held} = 0;
    cmd = DPSEM_CMD_ACQUIRE;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wait_done();
    for (i = 0; i < 8; i++) rwrite(1'b1, i[2:0]);
    cmp8("left flags", 8'hFF, lf);
    cmp8("left requests", 8'h00, reql);
    $display("test init done");
    base = $random(seed);
    for (i = 0; i < 8; i++) acq(i[2:0] ^ base[2:0], 1'b0, 1'b1);
    cmp8("left flags", 8'h00, lf);
    cmp8("right flags", 8'hFF, rf);
    acq(base[2:0], 1'b0, 1'b1);
    cmp8("right flags", 8'hFF, rf);
    for (i = 0; i < 8; i++) rel(i[2:0]);
    cmp8("left flags", 8'hFF, lf);
    cmp8("right flags", 8'hFF, rf);
    $display("test acquire all done");
    k = $random(seed);
    rwrite(1'b0, k);
    cmp1("right flag", 1'b0, rf[k]);
    cmp1("left flag", 1'b1, lf[k]);
    acq(k, 1'b0, 1'b0);
    cmp1("left request", 1'b0, reql[k]);
    rwrite(1'b1, k);
    cmp8("left flags", 8'hFF, lf);
    $display("test withdraw done");
    acq(k + 3'd1, 1'b0, 1'b1);
    rwrite(1'b0, k + 3'd1);
    cmp1("right flag", 1'b1, rf[k+3'd1]);
    rel(k + 3'd1);
    cmp1("right flag", 1'b0, rf[k+3'd1]);
    rwrite(1'b1, k + 3'd1);
    $display("test pass on done");
    rwrite(1'b0, k);
    fork
      acq(k, 1'b1, 1'b1);
      begin
        repeat (16) @(posedge clk);
        rwrite(1'b1, k);
      end
    join
    rel(k);
    $display("test polling done");
    for (i = 0; i < 24; i++) begin
      c = $unsigned($random(seed)) % 3;
      k = $random(seed);
      if (c == 0) acq(k, $random(seed), 1'b1);
      else if (c == 1) rel(k);
      else begin
        run(DPSEM_CMD_INIT, k, 1'b0);
        exp_held = 8'h00;
        cmp8("held", exp_held, held);
        cmp8("left flags", 8'hFF, lf);
      end
    end
    $display("test random done");
    give_verdict();
  end
endmodule : dpsem_port_ctrl_tb_top

`default_nettype wire

// ---- bench/dpsem_token_model.sv ----
`default_nettype none

module dpsem_token_model (
  input  wire logic       i_clk,     // Clock.
  input  wire logic       i_sel_n,   // Left select.
  input  wire logic       i_oe_n,    // Left enable.
  input  wire logic       i_rw_n,    // Left direction.
  input  wire logic [2:0] i_idx,     // Left index.
  input  wire logic [7:0] i_bus,     // Resolved data wire.
  input  wire logic       i_r_wr,    // Right write.
  input  wire logic       i_r_bit,   // Right value.
  input  wire logic [2:0] i_r_idx,   // Right index.
  output logic [7:0]      o_data,    // Read data.
  output logic            o_drive,   // Read data driven.
  output logic [7:0]      o_l_flags, // Left view.
  output logic [7:0]      o_r_flags, // Right view.
  output logic [7:0]      o_req_l    // Left requests.
);
  timeunit 1ns;
  timeprecision 100ps;

  // Power-up state is deliberately messy, so the host must clear it.
  logic [7:0] own_l = 8'h03;
  logic [7:0] own_r = 8'h30;
  logic [7:0] req_l = 8'hC5;
  logic [7:0] req_r = 8'h5A;
  logic       was_wr = 1'b0;
  logic       was_rd = 1'b0;
  logic       rd_val = 1'b1;

  // A held token reads zero on its holder's side only.
  assign o_l_flags = ~own_l;
  assign o_r_flags = ~own_r;
  assign o_req_l   = req_l;
  assign o_data    = {8{rd_val}};
  assign o_drive   = was_rd && !i_sel_n && !i_oe_n && i_rw_n;

  task automatic wr_side(input logic b, input logic [2:0] k, ref logic [7:0] own,
                         ref logic [7:0] req, ref logic [7:0] oth, ref logic [7:0] oreq);
    if (!b) begin
      req[k] = 1'b1;
      if (!oth[k]) own[k] = 1'b1;
    end else begin
      req[k] = 1'b0;
      if (own[k]) begin
        own[k] = 1'b0;
        oth[k] = oreq[k];
      end
    end
  endtask : wr_side

  // Left is served before right on a shared edge, which breaks a tie.
  always @(posedge i_clk) begin
    // Only the three index bits and data bit zero reach the latch logic.
    if (was_wr && !(!i_sel_n && !i_rw_n)) begin
      wr_side(i_bus[0], i_idx, own_l, req_l, own_r, req_r);
    end
    if (i_r_wr) wr_side(i_r_bit, i_r_idx, own_r, req_r, own_l, req_l);
    if (!i_sel_n && !i_oe_n && !was_rd) rd_val <= !own_l[i_idx];
    was_rd <= !i_sel_n && !i_oe_n;
    was_wr <= !i_sel_n && !i_rw_n;
  end
endmodule : dpsem_token_model

`default_nettype wire

// ---- logic/dpsem_pin_cycle.sv ----
`default_nettype none
`include "dpsem_regs.svh"

module dpsem_pin_cycle
  import dpsem_pkg::*;
#(
  parameter int IDX_W  = `DPSEM_IDX_W,
  parameter int DATA_W = `DPSEM_DATA_W
) (
  input  wire logic              i_clk,            // System clock.
  input  wire logic              i_reset,          // Synchronous reset, active high.
  input  wire logic              i_start,          // Start one pin cycle.
  input  wire logic              i_write,          // One for a write, zero for a read.
  input  wire logic [IDX_W-1:0]  i_index,          // Token latch to address.
  input  wire logic              i_wbit,           // Value written on data bit zero.
  input  wire logic [DATA_W-1:0] i_data_in,        // Data pins as seen from the port.
  output logic                   o_token_select_n, // Token select, active low.
  output logic                   o_oe_n,           // Output enable, active low.
  output logic                   o_rw_n,           // Read high, write low.
  output logic [IDX_W-1:0]       o_token_index,    // Low address bits.
  output logic [DATA_W-1:0]      o_data_out,       // Data driven on a write.
  output logic                   o_data_oe,        // High while data pins are driven.
  output logic                   o_done,           // One-cycle pulse at cycle end.
  output logic                   o_rbit            // Token value read back.
);

  localparam logic [3:0] ACC_CYC = 4'(`DPSEM_ACCESS_CYC);
  localparam logic [3:0] WPL_CYC = 4'(`DPSEM_WPULSE_CYC);

  dpsem_cyc_t        state;
  dpsem_cyc_t        next_state;
  logic [3:0]        count;
  logic [3:0]        next_count;
  logic              is_write;
  logic              next_is_write;
  logic              sel_n, next_sel_n, oe_n, next_oe_n, rw_n, next_rw_n;
  logic              doe, next_doe, done, next_done, rbit, next_rbit;
  logic [IDX_W-1:0]  idx, next_idx;
  logic [DATA_W-1:0] dout, next_dout;

  // Address and data settle a cycle before the select falls, and the select
  // rises again after every access so the device's read latch reopens.
  always_comb begin
    next_state    = state;
    next_count    = count;
    next_is_write = is_write;
    next_sel_n    = sel_n;
    next_oe_n     = oe_n;
    next_rw_n     = rw_n;
    next_doe      = doe;
    next_done     = 1'b0;
    next_rbit     = rbit;
    next_idx      = idx;
    next_dout     = dout;
    case (state)
      DPSEM_CY_IDLE: begin
        if (i_start) begin
          next_state    = DPSEM_CY_SETUP;
          next_is_write = i_write;
          next_idx      = i_index;
          next_dout     = {DATA_W{i_wbit}};
          next_doe      = i_write;
        end
      end
      DPSEM_CY_SETUP: begin
        next_state = DPSEM_CY_STROBE;
        next_sel_n = 1'b0;
        next_rw_n  = ~is_write;
        next_oe_n  = is_write;
        next_count = is_write ? WPL_CYC : ACC_CYC;
      end
      DPSEM_CY_STROBE: begin
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_state = DPSEM_CY_HOLD;
          next_sel_n = 1'b1;
          next_rw_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_rbit  = is_write ? rbit : i_data_in[0];
        end
      end
      DPSEM_CY_HOLD: begin
        // Data stays driven one cycle past the rising strobe edge.
        next_state = DPSEM_CY_IDLE;
        next_doe   = 1'b0;
        next_done  = 1'b1;
      end
      default: begin
        next_state = DPSEM_CY_IDLE;
      end
    endcase
  end

  // Registers of the pin cycle engine.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state    <= DPSEM_CY_IDLE;
      count    <= 4'h0;
      is_write <= 1'b0;
      sel_n    <= 1'b1;
      oe_n     <= 1'b1;
      rw_n     <= 1'b1;
      doe      <= 1'b0;
      done     <= 1'b0;
      rbit     <= 1'b1;
      idx      <= '0;
      dout     <= '1;
    end else begin
      state    <= next_state;
      count    <= next_count;
      is_write <= next_is_write;
      sel_n    <= next_sel_n;
      oe_n     <= next_oe_n;
      rw_n     <= next_rw_n;
      doe      <= next_doe;
      done     <= next_done;
      rbit     <= next_rbit;
      idx      <= next_idx;
      dout     <= next_dout;
    end
  end

  assign o_token_select_n = sel_n;
  assign o_oe_n           = oe_n;
  assign o_rw_n           = rw_n;
  assign o_token_index    = idx;
  assign o_data_out       = dout;
  assign o_data_oe        = doe;
  assign o_done           = done;
  assign o_rbit           = rbit;

endmodule : dpsem_pin_cycle

`default_nettype wire

// ---- logic/dpsem_pkg.sv ----
`default_nettype none

package dpsem_pkg;

  // Commands offered to the user of the port controller.
  typedef enum logic [1:0] {
    DPSEM_CMD_ACQUIRE,
    DPSEM_CMD_RELEASE,
    DPSEM_CMD_INIT
  } dpsem_cmd_t;

  // States of the main sequencer.
  typedef enum logic [2:0] {
    DPSEM_ST_INIT,
    DPSEM_ST_IDLE,
    DPSEM_ST_ACQ_WR,
    DPSEM_ST_ACQ_RD,
    DPSEM_ST_REL_WR,
    DPSEM_ST_WDRAW
  } dpsem_state_t;

  // States of the single pin cycle engine.
  typedef enum logic [1:0] {
    DPSEM_CY_IDLE,
    DPSEM_CY_SETUP,
    DPSEM_CY_STROBE,
    DPSEM_CY_HOLD
  } dpsem_cyc_t;

endpackage : dpsem_pkg

`default_nettype wire

// ---- logic/dpsem_port_ctrl.sv ----
`default_nettype none
`include "dpsem_regs.svh"

module dpsem_port_ctrl
  import dpsem_pkg::*;
#(
  parameter int NUM_TOKENS = `DPSEM_NUM_TOKENS,
  parameter int IDX_W      = `DPSEM_IDX_W,
  parameter int DATA_W     = `DPSEM_DATA_W,
  parameter int RETRY_MAX  = `DPSEM_RETRY_MAX
) (
  input  wire logic              i_clk,            // System clock, 40 MHz.
  input  wire logic              i_reset,          // Synchronous reset, active high.
  input  wire logic              i_cmd_valid,      // Command offered.
  input  wire dpsem_cmd_t        i_cmd,            // Acquire, release or init.
  input  wire logic [IDX_W-1:0]  i_cmd_index,      // Token the command acts on.
  input  wire logic              i_wait_on_fail,   // Keep polling a busy token.
  output logic                   o_cmd_ready,      // Command is taken when high.
  output logic                   o_done,           // One-cycle pulse at command end.
  output logic                   o_granted,        // Last acquire won its token and no release followed.
  output logic [NUM_TOKENS-1:0]  o_held,           // Tokens this port holds.
  output logic                   o_token_select_n, // Token select pin, active low.
  output logic                   o_ram_select_n,   // Memory chip enable, held high.
  output logic                   o_oe_n,           // Output enable pin, active low.
  output logic                   o_rw_n,           // Read high, write low.
  output logic [IDX_W-1:0]       o_token_index,    // Low address pins.
  input  wire logic [DATA_W-1:0] i_data_in,        // Data pins, input side.
  output logic [DATA_W-1:0]      o_data_out,       // Data pins, output side.
  output logic                   o_data_oe         // Data pins driven when high.
);

  localparam int RETRY_W = $clog2(RETRY_MAX + 1);
  localparam logic [IDX_W-1:0]   LAST_IDX = IDX_W'(NUM_TOKENS - 1);
  localparam logic [RETRY_W-1:0] RETRY_LIM = RETRY_W'(RETRY_MAX);

  dpsem_state_t          state;
  dpsem_state_t          next_state;
  logic [IDX_W-1:0]      idx, next_idx;
  logic [RETRY_W-1:0]    retry, next_retry;
  logic                  launched, next_launched;
  logic                  wait_fail, next_wait_fail;
  logic                  cmd_ready, next_cmd_ready;
  logic                  done, next_done;
  logic                  granted, next_granted;
  logic [NUM_TOKENS-1:0] held, next_held;
  logic                  ram_sel_n;
  logic                  cyc_start;
  logic                  cyc_write;
  logic                  cyc_wbit;
  logic                  cyc_done;
  logic                  cyc_rbit;

  // Returns the one-hot mask of a token index.
  function automatic logic [NUM_TOKENS-1:0] tok_mask(input logic [IDX_W-1:0] i);
    tok_mask = '0;
    tok_mask[i] = 1'b1;
  endfunction : tok_mask

  // Starts a pin cycle in any non-idle state when none is running; the launched flag drops when the
  // cycle ends so a repeated read in the same state runs a fresh cycle.
  function automatic logic first_go(input logic l);
    first_go = ~l;
  endfunction : first_go

  // Main sequencer. The latches power up in an unknown state, and pending
  // requests from this side may survive too, so the port refuses commands
  // until it has freed every latch itself.
  always_comb begin
    next_state     = state;
    next_idx       = idx;
    next_retry     = retry;
    next_launched  = launched;
    next_wait_fail = wait_fail;
    next_done      = 1'b0;
    next_granted   = granted;
    next_held      = held;
    cyc_start      = 1'b0;
    cyc_write      = 1'b1;
    cyc_wbit       = `DPSEM_TOKEN_FREE;
    if (cyc_done) begin
      next_launched = 1'b0;
    end else if (state != DPSEM_ST_IDLE && first_go(launched)) begin
      cyc_start     = 1'b1;
      next_launched = 1'b1;
    end
    case (state)
      DPSEM_ST_INIT: begin
        // Walk all latches writing one: frees own holds and own requests.
        if (cyc_done) begin
          next_held = '0;
          if (idx == LAST_IDX) begin
            next_state = DPSEM_ST_IDLE;
            next_idx   = '0;
            next_done  = 1'b1;
          end else begin
            next_idx = idx + IDX_W'(1);
          end
        end
      end
      DPSEM_ST_IDLE: begin
        if (i_cmd_valid && cmd_ready) begin
          next_idx       = i_cmd_index;
          next_retry     = '0;
          next_wait_fail = i_wait_on_fail;
          case (i_cmd)
            DPSEM_CMD_ACQUIRE: next_state = DPSEM_ST_ACQ_WR;
            DPSEM_CMD_RELEASE: next_state = DPSEM_ST_REL_WR;
            DPSEM_CMD_INIT: begin
              next_state = DPSEM_ST_INIT;
              next_idx   = '0;
            end
            default: next_state = DPSEM_ST_IDLE;
          endcase
        end
      end
      DPSEM_ST_ACQ_WR: begin
        // Request first, test after; a read-then-write order would race.
        cyc_wbit = `DPSEM_TOKEN_TAKE;
        if (cyc_done) begin
          next_state = DPSEM_ST_ACQ_RD;
        end
      end
      DPSEM_ST_ACQ_RD: begin
        cyc_write = 1'b0;
        if (cyc_done) begin
          if (cyc_rbit == `DPSEM_TOKEN_TAKE) begin
            next_state   = DPSEM_ST_IDLE;
            next_granted = 1'b1;
            next_held    = held | tok_mask(idx);
            next_done    = 1'b1;
          end else if (wait_fail && retry != RETRY_LIM) begin
            // Each poll reopens the select so the read latch can update.
            next_retry = retry + RETRY_W'(1);
          end else begin
            next_state = DPSEM_ST_WDRAW;
          end
        end
      end
      DPSEM_ST_WDRAW: begin
        // A lingering request would hand us the token later, unnoticed.
        if (cyc_done) begin
          next_state   = DPSEM_ST_IDLE;
          next_granted = 1'b0;
          next_done    = 1'b1;
        end
      end
      DPSEM_ST_REL_WR: begin
        if (cyc_done) begin
          next_state   = DPSEM_ST_IDLE;
          next_granted = 1'b0;
          next_held    = held & ~tok_mask(idx);
          next_done    = 1'b1;
        end
      end
      default: begin
        next_state = DPSEM_ST_INIT;
        next_idx   = '0;
      end
    endcase
    next_cmd_ready = (next_state == DPSEM_ST_IDLE) && !(state == DPSEM_ST_IDLE && i_cmd_valid &&
                     cmd_ready);
  end

  // Registers of the main sequencer.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state     <= DPSEM_ST_INIT;
      idx       <= '0;
      retry     <= '0;
      launched  <= 1'b0;
      wait_fail <= 1'b0;
      cmd_ready <= 1'b0;
      done      <= 1'b0;
      granted   <= 1'b0;
      held      <= '0;
      ram_sel_n <= 1'b1;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      retry     <= next_retry;
      launched  <= next_launched;
      wait_fail <= next_wait_fail;
      cmd_ready <= next_cmd_ready;
      done      <= next_done;
      granted   <= next_granted;
      held      <= next_held;
      ram_sel_n <= 1'b1;
    end
  end

  // Pin cycle engine; token write value goes out on every bit, bit zero counts.
  dpsem_pin_cycle #(
    .IDX_W  (IDX_W),
    .DATA_W (DATA_W)
  ) u_cycle (
    .i_clk            (i_clk),
    .i_reset          (i_reset),
    .i_start          (cyc_start),
    .i_write          (cyc_write),
    .i_index          (idx),
    .i_wbit           (cyc_wbit),
    .i_data_in        (i_data_in),
    .o_token_select_n (o_token_select_n),
    .o_oe_n           (o_oe_n),
    .o_rw_n           (o_rw_n),
    .o_token_index    (o_token_index),
    .o_data_out       (o_data_out),
    .o_data_oe        (o_data_oe),
    .o_done           (cyc_done),
    .o_rbit           (cyc_rbit)
  );

  assign o_cmd_ready    = cmd_ready;
  assign o_done         = done;
  assign o_granted      = granted;
  assign o_held         = held;
  assign o_ram_select_n = ram_sel_n;

endmodule : dpsem_port_ctrl

`default_nettype wire

// ---- logic/dpsem_regs.svh ----
`ifndef DPSEM_REGS_SVH
`define DPSEM_REGS_SVH

// Token latch geometry seen from one port.
`define DPSEM_NUM_TOKENS 8
`define DPSEM_IDX_W      3
`define DPSEM_DATA_W     8

// Flag values on the pins: a held token reads zero, a free one reads one.
`define DPSEM_TOKEN_TAKE 1'b0
`define DPSEM_TOKEN_FREE 1'b1

// Clock period and pin timing, each time in nanoseconds.
`define DPSEM_CLK_PERIOD_NS 25
`define DPSEM_T_ACCESS_NS   70
`define DPSEM_T_WPULSE_NS   60

// Least times round up to whole clock cycles.
`define DPSEM_ACCESS_CYC \
  ((`DPSEM_T_ACCESS_NS + `DPSEM_CLK_PERIOD_NS - 1) / `DPSEM_CLK_PERIOD_NS)
`define DPSEM_WPULSE_CYC \
  ((`DPSEM_T_WPULSE_NS + `DPSEM_CLK_PERIOD_NS - 1) / `DPSEM_CLK_PERIOD_NS)

// Default number of extra read-backs while waiting on a busy token.
`define DPSEM_RETRY_MAX 16

`endif
